// *** pcff_pkg.sv ***
package pcff_pkg;
	// Sizes
	localparam int NCH   = 8;
	localparam int CHW   = 3;
	localparam int DW    = 24;
	localparam int CW    = 16;
	localparam int AW    = 48;
	localparam int FRAC  = 14;
	localparam int TAPS  = 15;
	localparam int ICOEF = 10;
	localparam int RAW   = 9;
	// Register offsets within a channel block
	localparam logic [5:0] R_EN     = 6'h00;
	localparam logic [5:0] R_CTRL   = 6'h01;
	localparam logic [5:0] R_FIRCUT = 6'h02;
	localparam logic [5:0] R_IIRLO  = 6'h03;
	localparam logic [5:0] R_IIRHI  = 6'h04;
	localparam logic [5:0] R_STAT   = 6'h05;
	localparam logic [5:0] R_FIRC   = 6'h10;
	localparam logic [5:0] R_IIRC   = 6'h20;
	// Field positions
	localparam int F_FIR_EN = 0;
	localparam int F_IIR_EN = 1;
	localparam int F_ORD    = 0;
	localparam int F_MODE   = 4;
	// Limits and counts
	localparam logic [3:0]  ORD_MIN   = 4'h4;
	localparam logic [3:0]  ORD_MAX   = 4'hE;
	localparam logic [3:0]  FILL_SAT  = 4'hF;
	localparam logic [3:0]  BQ_LAST   = 4'h4;
	localparam logic [3:0]  BQ_STEP   = 4'h5;
	localparam logic [15:0] CUT_MAX   = 16'h7D70;
	typedef enum logic [1:0] {
		MODE_LP = 2'h0,
		MODE_HP = 2'h1,
		MODE_BP = 2'h2,
		MODE_BS = 2'h3
	} pcff_mode_t;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_FIR  = 4'b0010,
		ST_IIR  = 4'b0100,
		ST_PUSH = 4'b1000
	} pcff_st_t;
	typedef struct packed {
		logic             fir_en;
		logic             iir_en;
		logic [3:0]       fir_ord;
		pcff_mode_t       iir_mode;
		logic [15:0]      fir_cut;
		logic [15:0]      iir_lo;
		logic [15:0]      iir_hi;
	} pcff_cfg_t;
	localparam pcff_cfg_t CFG_RST = '{fir_en: 1'b0, iir_en: 1'b0, fir_ord: 4'h4,
		iir_mode: MODE_LP, fir_cut: 16'h2E15, iir_lo: 16'h1000, iir_hi: 16'h2000};
	typedef struct packed {
		logic [CHW-1:0]       chan;
		logic signed [DW-1:0] data;
	} pcff_smp_t;
	typedef struct packed {
		pcff_st_t                              st;
		logic [CHW-1:0]                        chan;
		logic signed [DW-1:0]                  x;
		logic signed [AW-1:0]                  acc;
		logic [3:0]                            idx;
		logic                                  sec;
		logic                                  in_rdy;
		logic [31:0]                           rdata;
		pcff_cfg_t [NCH-1:0]                   cfg;
		logic [NCH-1:0][3:0]                   fill;
		logic [NCH-1:0][TAPS-1:0][CW-1:0]      firc;
		logic [NCH-1:0][ICOEF-1:0][CW-1:0]     iirc;
		logic [NCH-1:0][TAPS-1:0][DW-1:0]      hist;
		logic [NCH-1:0][1:0][3:0][DW-1:0]      iirs;
	} pcff_core_t;
	function automatic logic pcff_ord_ok(input logic [3:0] o);
		return (o >= ORD_MIN) && (o <= ORD_MAX) && !o[0];
	endfunction : pcff_ord_ok
	function automatic logic pcff_fir_bad(input pcff_cfg_t c);
		logic [15:0] lo;
		logic [15:0] hi;
		case (c.fir_ord)
			4'hE: begin lo = 16'h0CCD; hi = 16'h30A3; end
			4'hC: begin lo = 16'h0F5D; hi = 16'h3999; end
			4'hA: begin lo = 16'h11EC; hi = 16'h451E; end
			4'h8: begin lo = 16'h170B; hi = 16'h570A; end
			4'h6: begin lo = 16'h1EB9; hi = 16'h5999; end
			default: begin lo = 16'h2E15; hi = 16'h68F5; end
		endcase
		return (c.fir_cut < lo) || (c.fir_cut > hi);
	endfunction : pcff_fir_bad
	function automatic logic pcff_iir_bad(input pcff_cfg_t c);
		return c.iir_mode[1] && (c.iir_lo >= c.iir_hi);
	endfunction : pcff_iir_bad
	function automatic logic signed [DW-1:0] pcff_sat(input logic signed [AW-1:0] a);
		logic signed [AW-1:0] t;
		t = a >>> FRAC;
		if (t > $signed({{(AW-DW+1){1'b0}}, {(DW-1){1'b1}}})) return {1'b0, {(DW-1){1'b1}}};
		if (t < $signed({{(AW-DW+1){1'b1}}, {(DW-1){1'b0}}})) return {1'b1, {(DW-1){1'b0}}};
		return t[DW-1:0];
	endfunction : pcff_sat
endpackage : pcff_pkg

// *** pcff_mac.sv ***
`timescale 1ns/1ps
module pcff_mac #(
	parameter int AW = 48,
	parameter int CW = 16,
	parameter int DW = 24
) (
	// Operands
	input  wire logic signed [AW-1:0] acc,
	input  wire logic signed [CW-1:0] coef,
	input  wire logic signed [DW-1:0] data,
	// Result
	output logic signed      [AW-1:0] sum
);
	logic signed [CW+DW-1:0] prod;

	assign prod = coef * data;
	assign sum  = acc + AW'(prod);
endmodule : pcff_mac

// *** pcff_buf2.sv ***
`timescale 1ns/1ps
module pcff_buf2 #(
	parameter int W = 27
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         resetn,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	typedef struct packed {
		logic         head_v;
		logic         spare_v;
		logic [W-1:0] head;
		logic [W-1:0] spare;
	} pcff_buf_t;

	pcff_buf_t b_reg;
	pcff_buf_t b_next;
	logic      take;
	logic      give;

	assign in_ready  = !b_reg.spare_v;
	assign out_valid = b_reg.head_v;
	assign out_data  = b_reg.head;
	assign take      = in_valid && !b_reg.spare_v;
	assign give      = b_reg.head_v && out_ready;

	always_comb begin
		b_next = b_reg;
		if (give) begin
			b_next.head_v  = b_reg.spare_v;
			b_next.head    = b_reg.spare;
			b_next.spare_v = 1'b0;
		end
		if (take) begin
			if (!b_reg.head_v || give) begin
				b_next.head   = in_data;
				b_next.head_v = 1'b1;
			end else begin
				b_next.spare   = in_data;
				b_next.spare_v = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			b_reg <= '0;
		end else begin
			b_reg <= b_next;
		end
	end

	chk_buf_hold_out: assert property (@(posedge ref_clk) disable iff (!resetn)
		(out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
		else $error("Stalled output changed");
	chk_buf_keep_word: assert property (@(posedge ref_clk) disable iff (!resetn)
		(take && b_reg.head_v && !give) |=> (b_reg.spare_v && b_reg.spare == $past(in_data)))
		else $error("Word lost while stalled");
endmodule : pcff_buf2

// *** pcff_filter.sv ***
// What this block does
// - First stage is a low-pass FIR with settable order and 3 dB cutoff.
// - After a step, FIR output settles once order plus one samples entered.
// - FIR order is 4 to 14, even; each order bounds cutoff per data rate.
// - Second stage is a fourth-order IIR: low, high, band pass or band stop.
// - Low and high pass IIR modes take one 3 dB cutoff.
// - Band modes take upper and lower cutoffs, never set equal; equal values are still accepted and flagged in status.
// - Band pass passes between cutoffs; band stop rejects between them.
// - Every IIR cutoff is limited to 0.49 times the data rate.
// - Each stage is set up and switched on or off per channel.
// - Switching a stage off keeps its stored settings.
// - Samples pass the FIR stage first, then the IIR stage.
`timescale 1ns/1ps
module pcff_filter
	import pcff_pkg::*;
(
	// Clock and reset
	input  wire logic           ref_clk,
	input  wire logic           resetn,
	// Register port
	input  wire logic [RAW-1:0] reg_addr,
	input  wire logic [31:0]    reg_wdata,
	input  wire logic           reg_wr,
	input  wire logic           reg_rd,
	output logic      [31:0]    reg_rdata,
	// Measured samples in
	input  wire logic           in_valid,
	output logic                in_ready,
	input  wire pcff_smp_t      in_smp,
	// Filtered samples out
	output logic                out_valid,
	input  wire logic           out_ready,
	output pcff_smp_t           out_smp
);
	pcff_core_t                 s_reg;
	pcff_core_t                 s_next;
	pcff_cfg_t                  cur;
	pcff_cfg_t                  acfg;
	pcff_cfg_t                  icfg;
	logic [CHW-1:0]             ach;
	logic [5:0]                 aoff;
	logic [3:0]                 ik;
	logic [3:0][DW-1:0]         sec_st;
	logic signed [CW-1:0]       op_c;
	logic signed [DW-1:0]       op_d;
	logic signed [AW-1:0]       mac_sum;
	logic signed [DW-1:0]       res;
	logic                       in_fire;
	logic                       buf_in_valid;
	logic                       buf_in_ready;
	logic                       firc_hit;
	logic                       iirc_hit;

	assign in_ready     = s_reg.in_rdy;
	assign reg_rdata    = s_reg.rdata;
	assign cur          = s_reg.cfg[s_reg.chan];
	assign acfg         = s_reg.cfg[ach];
	assign icfg         = s_reg.cfg[in_smp.chan];
	assign ach          = reg_addr[RAW-1:6];
	assign aoff         = reg_addr[5:0];
	assign sec_st       = s_reg.iirs[s_reg.chan][s_reg.sec];
	assign ik           = (s_reg.sec ? BQ_STEP : 4'h0) + s_reg.idx;
	assign res          = pcff_sat(mac_sum);
	assign in_fire      = in_valid && s_reg.in_rdy;
	assign buf_in_valid = (s_reg.st == ST_PUSH);
	assign firc_hit     = (aoff[5:4] == R_FIRC[5:4]) && (aoff[3:0] < 4'(TAPS));
	assign iirc_hit     = (aoff[5:4] == R_IIRC[5:4]) && (aoff[3:0] < 4'(ICOEF));

	// Operand select for the shared multiply-accumulate
	always_comb begin
		op_c = '0;
		op_d = '0;
		if (s_reg.st == ST_FIR) begin
			op_c = s_reg.firc[s_reg.chan][s_reg.idx];
			op_d = s_reg.hist[s_reg.chan][s_reg.idx];
		end else begin
			op_c = s_reg.iirc[s_reg.chan][ik];
			case (s_reg.idx)
				4'h0: op_d = s_reg.x;
				4'h1: op_d = sec_st[0];
				4'h2: op_d = sec_st[1];
				4'h3: op_d = sec_st[2];
				default: op_d = sec_st[3];
			endcase
		end
	end

	pcff_mac #(
		.AW(AW),
		.CW(CW),
		.DW(DW)
	) u_mac (
		.acc  (s_reg.acc),
		.coef (op_c),
		.data (op_d),
		.sum  (mac_sum)
	);

	always_comb begin
		s_next       = s_reg;
		s_next.rdata = '0;
		// Sample engine
		unique case (s_reg.st)
			ST_IDLE: begin
				if (in_fire) begin
					s_next.chan   = in_smp.chan;
					s_next.x      = in_smp.data;
					s_next.in_rdy = 1'b0;
					s_next.acc    = '0;
					s_next.idx    = 4'h0;
					s_next.sec    = 1'b0;
					s_next.hist[in_smp.chan] =
						{s_reg.hist[in_smp.chan][TAPS-2:0], in_smp.data};
					if (s_reg.fill[in_smp.chan] != FILL_SAT) begin
						s_next.fill[in_smp.chan] = s_reg.fill[in_smp.chan] + 4'h1;
					end
					if (icfg.fir_en) begin
						s_next.st = ST_FIR;
					end else if (icfg.iir_en) begin
						s_next.st = ST_IIR;
					end else begin
						s_next.st = ST_PUSH;
					end
				end
			end
			ST_FIR: begin
				s_next.acc = mac_sum;
				s_next.idx = s_reg.idx + 4'h1;
				if (s_reg.idx == cur.fir_ord) begin
					s_next.x   = res;
					s_next.acc = '0;
					s_next.idx = 4'h0;
					s_next.st  = cur.iir_en ? ST_IIR : ST_PUSH;
				end
			end
			ST_IIR: begin
				s_next.acc = mac_sum;
				s_next.idx = s_reg.idx + 4'h1;
				if (s_reg.idx == BQ_LAST) begin
					s_next.iirs[s_reg.chan][s_reg.sec] =
						{sec_st[2], res, sec_st[0], s_reg.x};
					s_next.x   = res;
					s_next.acc = '0;
					s_next.idx = 4'h0;
					s_next.sec = 1'b1;
					if (s_reg.sec) begin
						s_next.st = ST_PUSH;
					end
				end
			end
			ST_PUSH: begin
				if (buf_in_ready) begin
					s_next.st     = ST_IDLE;
					s_next.in_rdy = 1'b1;
				end
			end
		endcase
		// Register writes
		if (reg_wr) begin
			if (aoff == R_EN) begin
				s_next.cfg[ach].fir_en = reg_wdata[F_FIR_EN];
				s_next.cfg[ach].iir_en = reg_wdata[F_IIR_EN];
				if (reg_wdata[F_FIR_EN] && !acfg.fir_en) begin
					s_next.fill[ach] = 4'h0;
				end
			end
			if (aoff == R_CTRL) begin
				if (pcff_ord_ok(reg_wdata[F_ORD +: 4])) begin
					s_next.cfg[ach].fir_ord = reg_wdata[F_ORD +: 4];
					s_next.fill[ach]        = 4'h0;
				end
				s_next.cfg[ach].iir_mode = pcff_mode_t'(reg_wdata[F_MODE +: 2]);
			end
			if (aoff == R_FIRCUT) begin
				s_next.cfg[ach].fir_cut = reg_wdata[15:0];
			end
			if (aoff == R_IIRLO && reg_wdata[15:0] <= CUT_MAX) begin
				s_next.cfg[ach].iir_lo = reg_wdata[15:0];
			end
			if (aoff == R_IIRHI && reg_wdata[15:0] <= CUT_MAX) begin
				s_next.cfg[ach].iir_hi = reg_wdata[15:0];
			end
			if (firc_hit) begin
				s_next.firc[ach][aoff[3:0]] = reg_wdata[CW-1:0];
			end
			if (iirc_hit) begin
				s_next.iirc[ach][aoff[3:0]] = reg_wdata[CW-1:0];
			end
		end
		// Register reads
		if (reg_rd) begin
			if (aoff == R_EN) begin
				s_next.rdata = {30'h0000_0000, acfg.iir_en, acfg.fir_en};
			end else if (aoff == R_CTRL) begin
				s_next.rdata = {26'h000_0000, acfg.iir_mode, acfg.fir_ord};
			end else if (aoff == R_FIRCUT) begin
				s_next.rdata = {16'h0000, acfg.fir_cut};
			end else if (aoff == R_IIRLO) begin
				s_next.rdata = {16'h0000, acfg.iir_lo};
			end else if (aoff == R_IIRHI) begin
				s_next.rdata = {16'h0000, acfg.iir_hi};
			end else if (aoff == R_STAT) begin
				s_next.rdata = {28'h000_0000, !s_reg.in_rdy,
					s_reg.fill[ach] > acfg.fir_ord,
					pcff_iir_bad(acfg), pcff_fir_bad(acfg)};
			end else if (firc_hit) begin
				s_next.rdata = {16'h0000, s_reg.firc[ach][aoff[3:0]]};
			end else if (iirc_hit) begin
				s_next.rdata = {16'h0000, s_reg.iirc[ach][aoff[3:0]]};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_reg        <= '0;
			s_reg.st     <= ST_IDLE;
			s_reg.in_rdy <= 1'b1;
			for (int i = 0; i < NCH; i++) begin
				s_reg.cfg[i] <= CFG_RST;
			end
		end else begin
			s_reg <= s_next;
		end
	end

	pcff_buf2 #(
		.W($bits(pcff_smp_t))
	) u_buf (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.in_valid  (buf_in_valid),
		.in_ready  (buf_in_ready),
		.in_data   ({s_reg.chan, s_reg.x}),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_smp)
	);

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	sequence s_iir_enter;
		(s_reg.st != ST_IIR) ##1 (s_reg.st == ST_IIR);
	endsequence
	sequence s_iir_done;
		(s_reg.st == ST_IIR && s_reg.sec && s_reg.idx == BQ_LAST) ##1 (s_reg.st == ST_PUSH);
	endsequence

	chk_fir_tap_step: assert property (
		(s_reg.st == ST_FIR && s_reg.idx != cur.fir_ord)
		|=> (s_reg.st == ST_FIR && s_reg.idx == $past(s_reg.idx) + 4'h1))
		else $error("FIR tap walk broken");
	chk_fir_then_iir: assert property (
		(s_reg.st == ST_FIR && s_reg.idx == cur.fir_ord)
		|=> (s_reg.st == ($past(cur.iir_en) ? ST_IIR : ST_PUSH)))
		else $error("FIR did not hand on");
	chk_iir_span: assert property (
		s_iir_enter |-> ##9 s_iir_done)
		else $error("IIR pass not ten cycles");
	chk_order_hold: assert property (
		(reg_wr && ach == 3'h0 && aoff == R_CTRL && !pcff_ord_ok(reg_wdata[3:0]))
		|=> $stable(s_reg.cfg[0].fir_ord))
		else $error("Illegal order taken");
	chk_cut_limit: assert property (
		s_reg.cfg[0].iir_lo <= CUT_MAX && s_reg.cfg[0].iir_hi <= CUT_MAX)
		else $error("Cutoff above limit");
	chk_band_flag: assert property (
		(reg_rd && aoff == R_STAT && acfg.iir_mode[1] && acfg.iir_lo == acfg.iir_hi)
		|=> reg_rdata[1])
		else $error("Equal cutoffs not flagged");
	chk_cfg_kept: assert property (
		(reg_wr && ach == 3'h0 && aoff == R_EN)
		|=> ($stable(s_reg.cfg[0].fir_ord) && $stable(s_reg.firc[0])
			&& $stable(s_reg.cfg[0].iir_hi)))
		else $error("Switching changed settings");
	chk_bypass: assert property (
		(in_fire && !icfg.fir_en && !icfg.iir_en)
		|=> (s_reg.st == ST_PUSH && s_reg.x == $past(in_smp.data)))
		else $error("Bypass altered sample");
	chk_one_result: assert property (
		in_fire |-> ##[1:27] (s_reg.st == ST_PUSH))
		else $error("No result for sample");
	chk_settle_flag: assert property (
		(reg_rd && aoff == R_STAT && s_reg.fill[ach] <= acfg.fir_ord) |=> !reg_rdata[2])
		else $error("Settled flagged too early");
endmodule : pcff_filter

// *** pcff_src.sv ***
`timescale 1ns/1ps
module pcff_src
	import pcff_pkg::*;
(
	// Clock
	input  wire logic ref_clk,
	// Measured sample stream
	output logic      in_valid,
	input  wire logic in_ready,
	output pcff_smp_t in_smp
);
	initial begin
		in_valid = 1'b0;
		in_smp   = '0;
	end
	// Offer one sample and hold it until taken
	task automatic send(input logic [CHW-1:0] ch, input logic signed [DW-1:0] d);
		@(posedge ref_clk);
		in_valid <= 1'b1;
		in_smp   <= '{chan: ch, data: d};
		do @(posedge ref_clk); while (in_ready !== 1'b1);
		in_valid <= 1'b0;
		// Released lines show no stale sample
		in_smp   <= ~{ch, d};
	endtask : send
endmodule : pcff_src

// *** tb_per_channel_fir_iir_filter.sv ***
`timescale 1ns/1ps
module tb_per_channel_fir_iir_filter
	import pcff_pkg::*;
;
	logic           ref_clk;
	logic           resetn;
	logic [RAW-1:0] reg_addr;
	logic [31:0]    reg_wdata;
	logic           reg_wr;
	logic           reg_rd;
	logic [31:0]    reg_rdata;
	logic           in_valid;
	logic           in_ready;
	pcff_smp_t      in_smp;
	logic           out_valid;
	logic           out_ready;
	pcff_smp_t      out_smp;
	int             failures;
	int             cmp_count;
	pcff_smp_t      got_q[$];

	pcff_filter u_pcff_filter (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.in_valid  (in_valid),
		.in_ready  (in_ready),
		.in_smp    (in_smp),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_smp   (out_smp)
	);
	pcff_src u_pcff_src (
		.ref_clk  (ref_clk),
		.in_valid (in_valid),
		.in_ready (in_ready),
		.in_smp   (in_smp)
	);

	initial ref_clk = 1'b0;
	always #20 ref_clk = ~ref_clk;

	// Receiver side capture
	always @(posedge ref_clk) begin
		if (resetn === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
			got_q.push_back(out_smp);
		end
	end

	function automatic logic [RAW-1:0] ad(input int ch, input logic [5:0] off);
		return {ch[CHW-1:0], off};
	endfunction : ad

	task automatic wr(input logic [RAW-1:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [RAW-1:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_val

	task automatic cmp_smp(input pcff_smp_t got, input pcff_smp_t exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_smp

	task automatic chk_reg(input logic [RAW-1:0] a, input logic [31:0] exp);
		logic [31:0] d;
		rd(a, d);
		cmp_val(d, exp);
	endtask : chk_reg

	// Wait a bounded time for the next output word
	task automatic chk_smp(input int ch, input logic [DW-1:0] d);
		pcff_smp_t e;
		int        n;
		e.chan = ch[CHW-1:0];
		e.data = d;
		n = 0;
		while (got_q.size() == 0 && n < 300) begin
			@(posedge ref_clk);
			n++;
		end
		#1;
		if (got_q.size() == 0) cmp_smp('x, e);
		else cmp_smp(got_q.pop_front(), e);
	endtask : chk_smp

	task automatic t_reset;
		chk_reg(ad(1, R_EN), 32'h0000_0000);
		chk_reg(ad(1, R_CTRL), 32'h0000_0004);
		chk_reg(ad(1, R_FIRCUT), 32'h0000_2E15);
		chk_reg(ad(1, R_IIRLO), 32'h0000_1000);
		chk_reg(ad(1, R_IIRHI), 32'h0000_2000);
		cmp_val({31'h0, out_valid}, 32'h0000_0000);
		@(posedge ref_clk);
		#1;
		cmp_val(reg_rdata, 32'h0000_0000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_config;
		logic [3:0]  ords[6];
		logic [31:0] st;
		ords = '{4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE};
		for (int i = 0; i < 6; i++) begin
			wr(ad(1, R_CTRL), {26'h0, i[1:0], ords[i]});
			chk_reg(ad(1, R_CTRL), {26'h0, i[1:0], ords[i]});
		end
		wr(ad(1, R_CTRL), 32'h0000_0035);
		chk_reg(ad(1, R_CTRL), 32'h0000_003E);
		wr(ad(0, R_CTRL), 32'h0000_0005);
		chk_reg(ad(0, R_CTRL), 32'h0000_0004);
		wr(ad(0, R_EN), 32'h0000_0000);
		chk_reg(ad(0, R_CTRL), 32'h0000_0004);
		wr(ad(1, R_IIRHI), 32'h0000_7D71);
		chk_reg(ad(1, R_IIRHI), 32'h0000_2000);
		wr(ad(1, R_IIRHI), 32'h0000_7D70);
		chk_reg(ad(1, R_IIRHI), 32'h0000_7D70);
		rd(ad(1, R_STAT), st);
		cmp_val(st & 32'h0000_0003, 32'h0000_0000);
		wr(ad(1, R_IIRLO), 32'h0000_7D70);
		wr(ad(1, R_FIRCUT), 32'h0000_3100);
		rd(ad(1, R_STAT), st);
		cmp_val(st & 32'h0000_0003, 32'h0000_0003);
		wr(ad(1, 6'h3F), 32'hFFFF_FFFF);
		chk_reg(ad(1, 6'h3F), 32'h0000_0000);
		$display("test config done");
	endtask : t_config

	task automatic t_fir_step;
		logic [31:0] st;
		wr(ad(2, R_FIRC), 32'h0000_2000);
		wr(ad(2, R_FIRC + 6'h04), 32'h0000_2000);
		wr(ad(2, R_EN), 32'h0000_0001);
		for (int i = 0; i < 5; i++) begin
			u_pcff_src.send(3'h2, 24'h00_1000);
			chk_smp(2, (i == 4) ? 24'h00_1000 : 24'h00_0800);
			rd(ad(2, R_STAT), st);
			cmp_val(st & 32'h0000_0004, (i == 4) ? 32'h0000_0004 : 32'h0000_0000);
		end
		$display("test fir step done");
	endtask : t_fir_step

	task automatic t_chain_keep;
		wr(ad(2, R_IIRC), 32'h0000_2000);
		wr(ad(2, R_IIRC + 6'h05), 32'h0000_4000);
		wr(ad(2, R_EN), 32'h0000_0003);
		u_pcff_src.send(3'h2, 24'h00_1000);
		chk_smp(2, 24'h00_0800);
		wr(ad(2, R_EN), 32'h0000_0000);
		u_pcff_src.send(3'h2, 24'h00_0123);
		chk_smp(2, 24'h00_0123);
		chk_reg(ad(2, R_FIRC), 32'h0000_2000);
		chk_reg(ad(2, R_IIRC), 32'h0000_2000);
		chk_reg(ad(0, R_EN), 32'h0000_0000);
		wr(ad(2, R_EN), 32'h0000_0001);
		u_pcff_src.send(3'h2, 24'h00_1000);
		chk_smp(2, 24'h00_1000);
		$display("test chain and keep done");
	endtask : t_chain_keep

	task automatic t_buffer;
		pcff_smp_t e;
		u_pcff_src.send(3'h5, 24'h80_0001);
		chk_smp(5, 24'h80_0001);
		@(posedge ref_clk);
		out_ready <= 1'b0;
		for (int i = 1; i < 4; i++) u_pcff_src.send(3'h6, i[DW-1:0]);
		repeat (8) @(posedge ref_clk);
		#1;
		e = '{chan: 3'h6, data: 24'h00_0001};
		cmp_val({31'h0, in_ready}, 32'h0000_0000);
		cmp_smp(out_smp, e);
		@(posedge ref_clk);
		out_ready <= 1'b1;
		for (int i = 1; i < 4; i++) chk_smp(6, i[DW-1:0]);
		$display("test buffer done");
	endtask : t_buffer

	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out

	initial begin
		resetn    = 1'b0;
		reg_addr  = '0;
		reg_wdata = '0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		out_ready = 1'b1;
		failures  = 0;
		cmp_count = 0;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		t_reset();
		t_config();
		t_fir_step();
		t_chain_keep();
		t_buffer();
		close_out();
	end

	// Watchdog
	initial begin
		#(40 * 20000);
		failures++;
		close_out();
	end
endmodule : tb_per_channel_fir_iir_filter
